// file: conv_defines.svh
// constants for the serial converter control block
`ifndef CONV_DEFINES_SVH
`define CONV_DEFINES_SVH
// How it works
// RULE1: strobe goes low when a conversion starts, high when it ends
// RULE2: serial input bits are ignored while chip select is high
// RULE3: serial output is released while chip select is high
// RULE4: serial output changes only on falling serial clock edges; the code also loads the first result bit when a conversion ends
// RULE5: serial input is captured on each rising serial clock edge
// RULE6: a voltage conversion lasts 64 master clock periods
// RULE7: every conversion pass opens with 13 warm-up periods
// RULE8: three periods after the arithmetic load the output register
// RULE9: acquisition happens in period one of cycle one
// RULE10: hold opens in period two, charge moves in periods three and four
// RULE11: from cycle two on, reference sampled in periods two and four when needed
// RULE12: temperature equals second pass result minus first pass result
// RULE13: temperature skips the first load, taking 125 periods
// RULE14: host is serial master, clock at most 2.5MHz, polarity and phase zero
// RULE15: setup byte is start, 0000, power mode bits, internal reference bit
// RULE16: conversion byte is start, 010, four input pair bits
// RULE17: start bit armed after select falls, idle setup byte, or 16 output bits
// RULE18: result leaves as 16 bits msb first, zeros afterwards
// RULE19: sequencing runs only from the internal master oscillator

// ==========================================================
// sequencer lengths in master clock periods
`define WARM_TICKS 6'h0D
`define CYCLE_TICKS 6'h30
`define LOAD_TICKS 6'h03
`define VOLT_TICKS 7'h40
`define TEMP_TICKS 7'h7D
// ==========================================================
// serial framing
`define BYTE_LAST 4'h7
`define OUT_BITS 5'h10
`define CFG_TAG 4'h0
`define CONV_TAG 3'h2
// ==========================================================
// register byte offsets
`define OFF_STATUS 8'h00
`define OFF_IRQ_EN 8'h04
`define OFF_IRQ_CLR 8'h08
`define OFF_STATE 8'h0C
`define OFF_RESULT 8'h10
`define OFF_TEMP_SEL 8'h14
// ==========================================================
// status bit positions and reset values
`define ST_DONE 0
`define ST_CFG 1
`define IRQ_EN_RST 2'h0
`define TEMP_SEL_RST 16'h0000
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2
`endif

// file: conv_types_pkg.sv
// types shared by the converter control block
package conv_types_pkg;
  // sequencer states, one-hot
  typedef enum logic [3:0] {
    SEQ_IDLE = 4'h1,
    SEQ_WARM = 4'h2,
    SEQ_CYCLE = 4'h4,
    SEQ_LOAD = 4'h8
  } seq_state_t;
endpackage : conv_types_pkg

// file: pin_sync.sv
// two-flop synchroniser with edge detection for pin inputs
`timescale 1ns/1ps
module pin_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] RST_VAL = '0
) (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // raw pins
  input wire logic [W-1:0] pin_async,
  // synchronised level and edges
  output logic [W-1:0] level,
  output logic [W-1:0] rise,
  output logic [W-1:0] fall
);
  logic [W-1:0] meta_r;
  logic [W-1:0] sync_r;
  logic [W-1:0] prev_r;

  generate
    if (W < 1) begin : g_bad_width
      $error("pin_sync needs at least one pin");
    end
  endgenerate

  // first flop feeds only the second
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      meta_r <= RST_VAL;
      sync_r <= RST_VAL;
      prev_r <= RST_VAL;
    end else begin
      meta_r <= pin_async;
      sync_r <= meta_r;
      prev_r <= sync_r;
    end
  end

  // edges from the settled copies only
  assign level = sync_r;
  assign rise = sync_r & ~prev_r;
  assign fall = ~sync_r & prev_r;
endmodule : pin_sync

// file: osc_tick.sv
// internal master oscillator period tick derived from aclk
`timescale 1ns/1ps
module osc_tick #(
  parameter int DIV = 4
) (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // one pulse per master period
  output logic tick
);
  localparam int CW = (DIV > 1) ? $clog2(DIV) : 1;
  logic [CW-1:0] cnt_r;
  logic tick_r;

  generate
    if (DIV < 1) begin : g_bad_div
      $error("osc_tick divider must be at least one");
    end
  endgenerate

  // free-running divider, independent of the serial link
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cnt_r <= '0;
      tick_r <= 1'h0;
    end else if (cnt_r == CW'(DIV - 1)) begin
      cnt_r <= '0;
      tick_r <= 1'h1;
    end else begin
      cnt_r <= cnt_r + CW'(1);
      tick_r <= 1'h0;
    end
  end

  assign tick = tick_r;
endmodule : osc_tick

// file: serial_adc_conversion_ctrl.sv
// serial converter control: serial slave, conversion sequencer, axi4-lite registers
`timescale 1ns/1ps
`include "conv_defines.svh"
module serial_adc_conversion_ctrl #(
  parameter int OSC_DIV = 4
) (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // axi4-lite write address and data
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // axi4-lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // axi4-lite read
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // serial pins
  input wire logic serial_clock,
  input wire logic chip_select_n,
  input wire logic serial_in,
  output logic serial_out,
  output logic serial_out_oe,
  output logic conversion_strobe,
  // converter core
  input wire logic [12:0] adc_code,
  input wire logic ref_needed,
  output logic acquire,
  output logic track_hold_open,
  output logic charge_xfer,
  output logic ref_sample,
  // configuration seen by the analog side
  output logic [1:0] power_mode_bits,
  output logic internal_voltage_source_on,
  output logic [3:0] input_pair_choice,
  // interrupt
  output logic irq
);
  // ==========================================================
  // helpers
  function automatic logic reg_mapped(input logic [7:0] a);
    reg_mapped = (a == `OFF_STATUS) || (a == `OFF_IRQ_EN) || (a == `OFF_IRQ_CLR) ||
                 (a == `OFF_STATE) || (a == `OFF_RESULT) || (a == `OFF_TEMP_SEL);
  endfunction : reg_mapped

  function automatic logic [31:0] apply_strb(input logic [31:0] old_v,
                                             input logic [31:0] new_v,
                                             input logic [3:0] strb);
    logic [31:0] m;
    m = {{8{strb[3]}}, {8{strb[2]}}, {8{strb[1]}}, {8{strb[0]}}};
    apply_strb = (old_v & ~m) | (new_v & m);
  endfunction : apply_strb

  // ==========================================================
  // pin synchronisers and master tick
  logic [2:0] pin_lvl;
  logic [2:0] pin_rise;
  logic [2:0] pin_fall;
  logic tick;

  pin_sync #(.W(3), .RST_VAL(3'h2)) u_sync (
    .aclk(aclk),
    .aresetn(aresetn),
    .pin_async({serial_in, chip_select_n, serial_clock}),
    .level(pin_lvl),
    .rise(pin_rise),
    .fall(pin_fall)
  );

  osc_tick #(.DIV(OSC_DIV)) u_tick (
    .aclk(aclk),
    .aresetn(aresetn),
    .tick(tick)
  );

  wire sclk_rise = pin_rise[0];
  wire sclk_fall = pin_fall[0];
  wire cs_high = pin_lvl[1];
  wire cs_fall = pin_fall[1];
  wire cs_rise = pin_rise[1];
  wire din_s = pin_lvl[2];

  // ==========================================================
  // serial receive
  logic [7:0] rx_sr_r;
  logic [3:0] rx_cnt_r;
  logic arm_r;
  logic pend_r;
  logic [4:0] out_cnt_r;
  logic [15:0] tx_sr_r;
  logic so_r;
  logic oe_r;
  logic [1:0] pm_r;
  logic iref_r;
  logic [3:0] choice_r;
  conv_types_pkg::seq_state_t st_r;
  conv_types_pkg::seq_state_t st_nxt;

  wire busy = (st_r != conv_types_pkg::SEQ_IDLE) || pend_r;
  wire shift_in = sclk_rise && !cs_high && arm_r; // see RULE2
  wire byte_done = shift_in && (rx_cnt_r == `BYTE_LAST);
  wire [7:0] new_byte = {rx_sr_r[6:0], din_s};
  wire cfg_evt = byte_done && (new_byte[6:3] == `CFG_TAG);
  wire conv_evt = byte_done && (new_byte[6:4] == `CONV_TAG) && !busy;
  wire start_conv = pend_r && (sclk_fall || cs_rise);
  wire out_shift = sclk_fall && !cs_high;
  wire out_16 = out_shift && (out_cnt_r == `OUT_BITS - 5'h01);

  // capture one bit per rising edge, hunting a 1 as start
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rx_sr_r <= 8'h00;
      rx_cnt_r <= 4'h0;
    end else if (cs_fall) begin
      rx_cnt_r <= 4'h0;
    end else if (shift_in && (rx_cnt_r != 4'h0 || din_s)) begin
      rx_sr_r <= new_byte; // see RULE5
      rx_cnt_r <= (rx_cnt_r == `BYTE_LAST) ? 4'h0 : rx_cnt_r + 4'h1;
    end
  end

  // start bit arming
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arm_r <= 1'h0;
    end else if (cs_fall || out_16 || (cfg_evt && !busy)) begin
      arm_r <= 1'h1; // see RULE17
    end else if (conv_evt) begin
      arm_r <= 1'h0;
    end
  end

  // setup and conversion byte contents
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pm_r <= 2'h0;
      iref_r <= 1'h0;
      choice_r <= 4'h0;
      pend_r <= 1'h0;
    end else begin
      if (cfg_evt) begin
        pm_r <= new_byte[2:1];
        iref_r <= new_byte[0];
      end
      if (conv_evt) begin
        choice_r <= new_byte[3:0];
      end
      pend_r <= conv_evt || (pend_r && !start_conv);
    end
  end

  // ==========================================================
  // conversion sequencer, launched by start_conv, then stepped by the master tick only
  logic [5:0] cnt_r;
  logic [5:0] cnt_nxt;
  logic pass_r;
  logic pass_nxt;
  logic temp_r;
  logic [12:0] code_a_r;
  logic [15:0] result_r;
  logic strobe_r;
  logic [15:0] temp_sel_r;
  logic [6:0] conv_ticks_r;

  wire pass_end = (st_r == conv_types_pkg::SEQ_CYCLE) && tick && // see RULE6
                  (cnt_r == `CYCLE_TICKS - 6'h01);
  wire done_evt = (st_r == conv_types_pkg::SEQ_LOAD) && tick &&
                  (cnt_r == `LOAD_TICKS - 6'h01);
  wire [12:0] temp_diff = adc_code - code_a_r; // see RULE12
  wire [15:0] result_word = temp_r ? {2'h0, temp_diff[11:0], 2'h0} :
                                     {adc_code[12], adc_code, 2'h0};

  // next state: warm-up, twelve cycles, then load or second pass
  always_comb begin
    st_nxt = st_r;
    cnt_nxt = cnt_r;
    pass_nxt = pass_r;
    case (st_r)
      conv_types_pkg::SEQ_IDLE: begin
        if (start_conv) begin
          st_nxt = conv_types_pkg::SEQ_WARM;
          cnt_nxt = 6'h00;
          pass_nxt = 1'h0;
        end
      end
      conv_types_pkg::SEQ_WARM: begin
        if (tick && cnt_r == `WARM_TICKS - 6'h01) begin
          st_nxt = conv_types_pkg::SEQ_CYCLE; // see RULE7
          cnt_nxt = 6'h00;
        end else if (tick) begin
          cnt_nxt = cnt_r + 6'h01;
        end
      end
      conv_types_pkg::SEQ_CYCLE: begin
        if (pass_end && temp_r && !pass_r) begin
          st_nxt = conv_types_pkg::SEQ_WARM; // see RULE13
          cnt_nxt = 6'h00;
          pass_nxt = 1'h1;
        end else if (pass_end) begin
          st_nxt = conv_types_pkg::SEQ_LOAD;
          cnt_nxt = 6'h00;
        end else if (tick) begin
          cnt_nxt = cnt_r + 6'h01;
        end
      end
      conv_types_pkg::SEQ_LOAD: begin
        if (done_evt) begin
          st_nxt = conv_types_pkg::SEQ_IDLE; // see RULE8
          cnt_nxt = 6'h00;
        end else if (tick) begin
          cnt_nxt = cnt_r + 6'h01;
        end
      end
      default: begin
        st_nxt = conv_types_pkg::SEQ_IDLE;
        cnt_nxt = 6'h00;
      end
    endcase
  end

  // sequencer state
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_r <= conv_types_pkg::SEQ_IDLE;
      cnt_r <= 6'h00;
      pass_r <= 1'h0;
    end else begin
      st_r <= st_nxt; // see RULE19
      cnt_r <= cnt_nxt;
      pass_r <= pass_nxt;
    end
  end

  // pass results and strobe
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      temp_r <= 1'h0;
      code_a_r <= 13'h0000;
      result_r <= 16'h0000;
      strobe_r <= 1'h1;
    end else begin
      if (start_conv) begin
        temp_r <= temp_sel_r[choice_r];
        strobe_r <= 1'h0; // see RULE1
      end else if (done_evt) begin
        strobe_r <= 1'h1; // see RULE1
      end
      if (pass_end && temp_r && !pass_r) begin
        code_a_r <= adc_code;
      end else if (pass_end) begin
        result_r <= result_word;
      end
    end
  end

  // phase decode within four-period cycles
  wire in_cycle = (st_r == conv_types_pkg::SEQ_CYCLE);
  wire first_cyc = (cnt_r[5:2] == 4'h0);
  wire acq_w = in_cycle && (cnt_r == 6'h00); // see RULE9
  wire hold_w = in_cycle && (cnt_r == 6'h01); // see RULE10
  wire xfer_w = in_cycle && first_cyc && cnt_r[1]; // see RULE10
  wire ref_w = in_cycle && !first_cyc && cnt_r[0] && ref_needed; // see RULE11
  logic acq_r;
  logic hold_r;
  logic xfer_r;
  logic ref_r;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      acq_r <= 1'h0;
      hold_r <= 1'h0;
      xfer_r <= 1'h0;
      ref_r <= 1'h0;
    end else begin
      acq_r <= acq_w;
      hold_r <= hold_w;
      xfer_r <= xfer_w;
      ref_r <= ref_w;
    end
  end

  // ==========================================================
  // serial transmit: load at end, shift on falling edges
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tx_sr_r <= 16'h0000;
      so_r <= 1'h0;
      out_cnt_r <= `OUT_BITS; // saturated, so no re-arm before a first load
      oe_r <= 1'h0;
    end else begin
      oe_r <= !cs_high; // see RULE3
      if (done_evt) begin
        tx_sr_r <= result_r; // see RULE18
        so_r <= result_r[15];
        out_cnt_r <= 5'h00;
      end else if (out_shift) begin
        tx_sr_r <= {tx_sr_r[14:0], 1'h0}; // see RULE18
        so_r <= tx_sr_r[14]; // see RULE4
        if (out_cnt_r != `OUT_BITS) begin
          out_cnt_r <= out_cnt_r + 5'h01;
        end
      end
    end
  end

  // ==========================================================
  // axi4-lite slave
  logic awready_r;
  logic wready_r;
  logic bvalid_r;
  logic [1:0] bresp_r;
  logic arready_r;
  logic rvalid_r;
  logic [1:0] rresp_r;
  logic [31:0] rdata_r;
  logic [7:0] aw_addr_r;
  logic [31:0] w_data_r;
  logic [3:0] w_strb_r;
  logic aw_got_r;
  logic w_got_r;
  logic [1:0] status_r;
  logic [1:0] irq_en_r;
  logic irq_r;

  wire wr_en = aw_got_r && w_got_r && !bvalid_r;
  wire wr_ien = wr_en && (aw_addr_r == `OFF_IRQ_EN);
  wire wr_clr = wr_en && (aw_addr_r == `OFF_IRQ_CLR);
  wire wr_tsel = wr_en && (aw_addr_r == `OFF_TEMP_SEL);
  wire [31:0] ien_new = apply_strb({30'h0000_0000, irq_en_r}, w_data_r, w_strb_r);
  wire [31:0] tsel_new = apply_strb({16'h0000, temp_sel_r}, w_data_r, w_strb_r);
  wire [1:0] clr_bits = wr_clr && w_strb_r[0] ? w_data_r[1:0] : 2'h0;
  wire [1:0] set_bits = {cfg_evt, done_evt};
  wire [1:0] status_nxt = (status_r & ~clr_bits) | set_bits; // set wins
  wire [31:0] state_word = {23'h00_0000, temp_r, busy, iref_r, pm_r, choice_r};
  wire [31:0] rd_word =
    (s_axi_araddr == `OFF_STATUS) ? {30'h0000_0000, status_r} :
    (s_axi_araddr == `OFF_IRQ_EN) ? {30'h0000_0000, irq_en_r} :
    (s_axi_araddr == `OFF_STATE) ? state_word :
    (s_axi_araddr == `OFF_RESULT) ? {16'h0000, result_r} :
    (s_axi_araddr == `OFF_TEMP_SEL) ? {16'h0000, temp_sel_r} : 32'h0000_0000;

  // write channels taken in either order, response after both
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awready_r <= 1'h1;
      wready_r <= 1'h1;
      aw_got_r <= 1'h0;
      w_got_r <= 1'h0;
      aw_addr_r <= 8'h00;
      w_data_r <= 32'h0000_0000;
      w_strb_r <= 4'h0;
      bvalid_r <= 1'h0;
      bresp_r <= `RESP_OKAY;
    end else begin
      if (s_axi_awvalid && awready_r) begin
        aw_addr_r <= s_axi_awaddr;
        aw_got_r <= 1'h1;
        awready_r <= 1'h0;
      end
      if (s_axi_wvalid && wready_r) begin
        w_data_r <= s_axi_wdata;
        w_strb_r <= s_axi_wstrb;
        w_got_r <= 1'h1;
        wready_r <= 1'h0;
      end
      if (wr_en) begin
        aw_got_r <= 1'h0;
        w_got_r <= 1'h0;
        bvalid_r <= 1'h1;
        bresp_r <= reg_mapped(aw_addr_r) ? `RESP_OKAY : `RESP_SLVERR;
      end else if (bvalid_r && s_axi_bready) begin
        bvalid_r <= 1'h0;
        awready_r <= 1'h1;
        wready_r <= 1'h1;
      end
    end
  end

  // read answer one cycle after the address
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready_r <= 1'h1;
      rvalid_r <= 1'h0;
      rresp_r <= `RESP_OKAY;
      rdata_r <= 32'h0000_0000;
    end else if (s_axi_arvalid && arready_r) begin
      arready_r <= 1'h0;
      rvalid_r <= 1'h1;
      rdata_r <= rd_word;
      rresp_r <= reg_mapped(s_axi_araddr) ? `RESP_OKAY : `RESP_SLVERR;
    end else if (rvalid_r && s_axi_rready) begin
      rvalid_r <= 1'h0;
      arready_r <= 1'h1;
    end
  end

  // software registers, sticky status and interrupt
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_en_r <= `IRQ_EN_RST;
      temp_sel_r <= `TEMP_SEL_RST;
      status_r <= 2'h0;
      irq_r <= 1'h0;
    end else begin
      if (wr_ien) begin
        irq_en_r <= ien_new[1:0];
      end
      if (wr_tsel) begin
        temp_sel_r <= tsel_new[15:0];
      end
      status_r <= status_nxt;
      irq_r <= |(status_nxt & (wr_ien ? ien_new[1:0] : irq_en_r));
    end
  end

  // ==========================================================
  // outputs
  assign s_axi_awready = awready_r;
  assign s_axi_wready = wready_r;
  assign s_axi_bvalid = bvalid_r;
  assign s_axi_bresp = bresp_r;
  assign s_axi_arready = arready_r;
  assign s_axi_rvalid = rvalid_r;
  assign s_axi_rresp = rresp_r;
  assign s_axi_rdata = rdata_r;
  assign serial_out = so_r;
  assign serial_out_oe = oe_r;
  assign conversion_strobe = strobe_r;
  assign acquire = acq_r;
  assign track_hold_open = hold_r;
  assign charge_xfer = xfer_r;
  assign ref_sample = ref_r;
  assign power_mode_bits = pm_r;
  assign internal_voltage_source_on = iref_r;
  assign input_pair_choice = choice_r;
  assign irq = irq_r;

  // ==========================================================
  // checks
  always_ff @(posedge aclk) begin
    if (!aresetn || start_conv) begin
      conv_ticks_r <= 7'h00;
    end else if (tick && st_r != conv_types_pkg::SEQ_IDLE) begin
      conv_ticks_r <= conv_ticks_r + 7'h01;
    end
  end

  // ticks already counted when the last one of a conversion arrives
  wire [6:0] conv_len_w = temp_r ? `TEMP_TICKS - 7'h01 : `VOLT_TICKS - 7'h01;

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  sequence s_launch;
    start_conv;
  endsequence
  sequence s_finish;
    done_evt;
  endsequence

  AST_STROBE_LOW: assert property (s_launch |=> !conversion_strobe [*8]) // see RULE1
    else $error("strobe not low after conversion start");
  AST_NO_SHIFT_CS_HIGH: assert property (cs_high |=> $stable(rx_sr_r)) // see RULE2
    else $error("input shifted while chip select high");
  AST_OE_OFF: assert property (cs_high ##1 cs_high |=> !serial_out_oe) // see RULE3
    else $error("serial output driven while chip select high");
  AST_OUT_ON_FALL: assert property ($changed(serial_out) |-> $past(out_shift || done_evt)) // see RULE4
    else $error("serial output changed away from a falling edge");
  AST_CAPTURE: assert property (shift_in && rx_cnt_r != 4'h0 |=> rx_sr_r[0] == $past(din_s)) // see RULE5
    else $error("serial input bit not captured");
  AST_CONV_LEN: assert property (s_finish |-> conv_ticks_r == conv_len_w) // see RULE6
    else $error("conversion length wrong");
  AST_WARM: assert property (st_r == conv_types_pkg::SEQ_WARM |-> cnt_r < `WARM_TICKS) // see RULE7
    else $error("warm-up overran");
  AST_LOAD_END: assert property (s_finish |=> conversion_strobe && serial_out == $past(result_r[15])) // see RULE8
    else $error("output register not loaded at end");
  AST_ACQ: assert property (acq_w && tick |=> acquire ##1 !acquire) // see RULE9
    else $error("acquisition outside first period");
  AST_XFER: assert property (hold_w && tick |=> track_hold_open ##1 charge_xfer [*2]) // see RULE10
    else $error("hold and transfer out of order");
  AST_REF: assert property (ref_sample |-> $past(in_cycle && !first_cyc && cnt_r[0])) // see RULE11
    else $error("reference sampled in wrong period");
  AST_TEMP_TWO_PASS: assert property (pass_end && temp_r && !pass_r |=> st_r == conv_types_pkg::SEQ_WARM && pass_r) // see RULE13
    else $error("temperature first pass not skipping load");
endmodule : serial_adc_conversion_ctrl

// file: spi_host_model.sv
// host serial master model driving mode-0 frames
`timescale 1ns/1ps
module spi_host_model (
  // clock
  input wire logic aclk,
  // serial pins
  output logic serial_clock,
  output logic chip_select_n,
  output logic serial_in,
  input wire logic serial_out,
  input wire logic serial_out_oe
);
  // idle levels, clock stands low outside frames
  initial begin
    serial_clock = 1'b0;
    chip_select_n = 1'b1;
    serial_in = 1'b0;
  end
  // wait whole aclk cycles
  task tk(input int n);
    repeat (n) @(posedge aclk);
  endtask : tk
  // change select, line shows inverse of last bit
  task sel(input logic lvl);
    chip_select_n <= lvl;
    serial_in <= ~serial_in;
    tk(4);
  endtask : sel
  // byte msb first, 800 ns period, polarity and phase zero
  task xfer(input logic [7:0] b);
    for (int i = 7; i >= 0; i--) begin
      serial_in <= b[i];
      tk(4);
      serial_clock <= 1'b1;
      tk(4);
      serial_clock <= 1'b0;
    end
  endtask : xfer
  // sixteen bits sampled at rising clock edges
  task rd16(output logic [15:0] v);
    serial_in <= 1'b0;
    for (int i = 15; i >= 0; i--) begin
      tk(4);
      v[i] = serial_out_oe ? serial_out : ~serial_out;
      serial_clock <= 1'b1;
      tk(4);
      serial_clock <= 1'b0;
    end
  endtask : rd16
endmodule : spi_host_model

// file: serial_adc_conversion_ctrl_tb.sv
// self-checking bench for the serial converter control block
`timescale 1ns/1ps
module serial_adc_conversion_ctrl_tb;
  localparam int DIV = 2;
  logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, refn, iref;
  logic awready, wready, bvalid, arready, rvalid, sclk, cs_n, din, dout, doe, stb, irq;
  logic acq, tho, cxf, rsp;
  logic [1:0] bresp, rresp, pm, rs;
  logic [3:0] wstrb, sel, s, saw = 4'h0;
  logic [7:0] awaddr, araddr;
  logic [12:0] code, c1, c2;
  logic [15:0] v, e;
  logic [31:0] wdata, rdata, r, exp_q[$], obs_q[$];
  int failures, tests_run, seed, lowcnt = 0, dur = 0;
  // ==========================================
  // design and host model
  serial_adc_conversion_ctrl #(.OSC_DIV(DIV)) u_dut (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .serial_clock(sclk), .chip_select_n(cs_n), .serial_in(din), .serial_out(dout),
    .serial_out_oe(doe), .conversion_strobe(stb), .adc_code(code), .ref_needed(refn),
    .acquire(acq), .track_hold_open(tho), .charge_xfer(cxf), .ref_sample(rsp),
    .power_mode_bits(pm), .internal_voltage_source_on(iref), .input_pair_choice(sel),
    .irq(irq));
  spi_host_model u_host (.aclk(aclk), .serial_clock(sclk), .chip_select_n(cs_n),
    .serial_in(din), .serial_out(dout), .serial_out_oe(doe));
  // ==========================================
  // clock
  initial begin
    aclk = 1'b0;
    forever #50 aclk = ~aclk;
  end
  // strobe low time, phase activity, random reference requests
  always @(posedge aclk) begin
    refn <= 1'($random(seed));
    if (!stb) begin
      lowcnt <= lowcnt + 1;
      saw <= (lowcnt == 0) ? {acq, tho, cxf, rsp} : saw | {acq, tho, cxf, rsp};
    end else if (lowcnt != 0) begin
      dur <= lowcnt;
      lowcnt <= 0;
    end
  end
  // compare oldest observation with oldest note
  always @(posedge aclk)
    if (obs_q.size() > 0) check(obs_q.pop_front(), exp_q.pop_front());
  // watchdog
  initial begin
    repeat (20000) @(posedge aclk);
    failures++;
    print_verdict();
  end
  // ==========================================
  // helpers
  task check(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      failures++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task note(input logic [31:0] so, input logic [31:0] ex);
    obs_q.push_back(so);
    exp_q.push_back(ex);
  endtask : note
  task print_verdict();
    $display("comparisons %0d failures %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : print_verdict
  task wr(input logic [7:0] a, input logic [31:0] d);
    logic aw, w, b;
    aw = 1'b1;
    w = 1'b1;
    b = 1'b1;
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (b) begin
      @(posedge aclk);
      if (aw && awready) begin
        aw = 1'b0;
        awvalid <= 1'b0;
      end
      if (w && wready) begin
        w = 1'b0;
        wvalid <= 1'b0;
      end
      if (bvalid === 1'b1) begin
        b = 1'b0;
        rs = bresp;
      end
    end
  endtask : wr
  task rd(input logic [7:0] a);
    logic ar, rw;
    ar = 1'b1;
    rw = 1'b1;
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    while (rw) begin
      @(posedge aclk);
      if (ar && arready) begin
        ar = 1'b0;
        arvalid <= 1'b0;
      end
      if (rvalid === 1'b1) begin
        rw = 1'b0;
        r = rdata;
        rs = rresp;
      end
    end
  endtask : rd
  task wstb(input logic lvl);
    int n;
    n = 0;
    while (stb !== lvl && n < 3000) begin
      @(posedge aclk);
      n++;
    end
    if (n >= 3000) failures++;
  endtask : wstb
  // one conversion, code changes after a voltage conversion ends or during a temperature second pass
  task conv(input logic tmp);
    int n;
    n = tmp ? 125 : 64;
    c1 = 13'($random(seed));
    c2 = 13'($random(seed));
    code <= c1;
    u_host.xfer({4'ha, s});
    wstb(1'b0);
    repeat (90 * DIV) @(posedge aclk);
    code <= c2;
    wstb(1'b1);
    u_host.rd16(v);
    e = tmp ? {2'h0, 12'(c2 - c1), 2'h0} : {c1[12], c1, 2'h0};
    note(v, e);
    note(sel, s);
    note(saw, 4'hf);
    note(dur >= n * DIV - DIV && dur <= n * DIV + DIV, 1);
    rd(8'h10);
    note(r, {16'h0, e});
  endtask : conv
  // ==========================================
  // main sequence
  initial begin
    {aresetn, awvalid, wvalid, bready, arvalid, rready} = '0;
    {awaddr, araddr, wdata, code} = '0;
    {failures, tests_run} = '0;
    wstrb = 4'hf;
    seed = 32'h0000_7578;
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (3) @(posedge aclk);
    rd(8'h04);
    note(r, 0);
    rd(8'h14);
    note(r, 0);
    rd(8'h20);
    note({rs, r[29:0]}, 32'h8000_0000);
    wr(8'h20, 0);
    note(rs, 2);
    wr(8'h04, 2);
    // setup byte with random power mode and reference, raises interrupt
    s = 4'($random(seed));
    u_host.sel(1'b0);
    u_host.xfer({5'h10, s[2:0]});
    repeat (4) @(posedge aclk);
    note({pm, iref}, s[2:0]);
    note(irq, 1);
    rd(8'h00);
    note(r, 2);
    wr(8'h08, 2);
    repeat (3) @(posedge aclk);
    note(irq, 0);
    // conversion byte while deselected is dropped
    u_host.sel(1'b1);
    u_host.xfer(8'ha3);
    repeat (4) @(posedge aclk);
    note(stb, 1);
    note(doe, 0);
    // voltage, trailing zeros, then temperature in the same frame
    u_host.sel(1'b0);
    note(doe, 1);
    conv(1'b0);
    u_host.rd16(v);
    note(v, 0);
    wr(8'h14, 32'h1 << s);
    note(rs, 0);
    conv(1'b1);
    u_host.sel(1'b1);
    note(doe, 0);
    repeat (2) @(posedge aclk);
    print_verdict();
  end
endmodule : serial_adc_conversion_ctrl_tb
